// ===== rtl/scp_defines.svh
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define SCP_CLK_PERIOD_NS    20
// Chopper oscillator tick: 50 MHz / 1600 kHz is about 31 clocks
`define SCP_OSC_DIV          5'd30
// Chopping period in oscillator ticks (1600 kHz / 100 kHz)
`define SCP_CHOP_TICKS       4'hf
// Fast decay share: 37.5 % of 16 ticks = 6 ticks
`define SCP_SPLIT_TICKS      4'h6
// Blanking 200..500 ns, least time rounded up
`define SCP_BLANK_NS         200
`define SCP_BLANK_CYC        ((`SCP_BLANK_NS + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS)
// Overcurrent mask, in oscillator ticks
`define SCP_OC_MASK_TICKS    3'h4

`endif

// ===== rtl/scp_pkg.sv
package scp_pkg;

  typedef enum logic [3:0] {
    SCP_OFF    = 4'b0001,
    SCP_CHARGE = 4'b0010,
    SCP_FAST   = 4'b0100,
    SCP_SLOW   = 4'b1000
  } scp_mode_t;

  typedef struct packed {
    logic high_side_first;
    logic high_side_second;
    logic low_side_first;
    logic low_side_second;
  } scp_gates_t;

endpackage

// ===== rtl/scp_bridge.sv
`timescale 1ns/10ps
`default_nettype none
`include "scp_defines.svh"

// One H-bridge chopper: mode machine, blanking and gate pattern
module scp_bridge
  import scp_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  input  wire logic       run_i,
  input  wire logic       period_start_i,
  input  wire logic       split_i,
  input  wire logic       mixed_i,
  input  wire logic       dir_i,
  input  wire logic       peak_i,
  output scp_pkg::scp_gates_t gates_o
);
  import scp_pkg::*;

  scp_mode_t  mode_q,  mode_d;
  logic [4:0] blank_q, blank_d;
  scp_gates_t gates_q, gates_d;

  function automatic scp_gates_t pattern(input scp_mode_t m, input logic fwd);
    scp_gates_t g;
    g = '0;
    case (m)
      SCP_CHARGE: g = fwd ? 4'b1001 : 4'b0110;
      SCP_SLOW:   g = 4'b0011;
      SCP_FAST:   g = fwd ? 4'b0110 : 4'b1001;
      default:    g = '0;
    endcase
    return g;
  endfunction

  always_comb begin
    mode_d  = mode_q;
    blank_d = (blank_q != 5'h0) ? blank_q - 5'h1 : blank_q;
    if (!run_i) begin
      mode_d = SCP_OFF;
    end else if (period_start_i) begin
      mode_d = SCP_CHARGE;
    end else begin
      case (mode_q)
        SCP_CHARGE: begin
          if (peak_i && blank_q == 5'h0) begin
            mode_d = mixed_i ? SCP_FAST : SCP_SLOW;
          end
        end
        SCP_FAST: begin
          if (split_i) begin
            mode_d = SCP_SLOW;
          end
        end
        SCP_SLOW: mode_d = SCP_SLOW;
        SCP_OFF:  mode_d = SCP_OFF;
        default:  mode_d = SCP_OFF;
      endcase
    end
    if (mode_d != mode_q) begin
      blank_d = 5'(`SCP_BLANK_CYC);
    end
    gates_d = pattern(mode_d, dir_i);
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q  <= SCP_OFF;
      blank_q <= 5'h0;
      gates_q <= '0;
    end else if (ce_i) begin
      mode_q  <= mode_d;
      blank_q <= blank_d;
      gates_q <= gates_d;
    end
  end

  assign gates_o = gates_q;

endmodule

`default_nettype wire

// ===== rtl/scp_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "scp_defines.svh"

// Summary of operation
// - Thermal trip resets, all transistors off
// - Thermal fault held until standby released High
// - Overcurrent trip resets, all transistors off
// - Overcurrent ignored for four oscillator ticks
// - Outputs off three to four ticks after overcurrent starts
// - Overcurrent latched until standby rises
// - Latched overcurrent behaves like standby, but the chopper oscillator keeps running
// - Resume chopping within four ticks after release
// - Mixed decay: fast 37.5 percent, then slow
// - Period counter, restarts each period
// - Forward gate patterns per mode
// - Reverse gate patterns per mode
// - Mode changes are automatic
// - Ignore sense for blanking after switching
module scp_core
  import scp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  // Host controls
  input  wire logic       standby_n_i,
  input  wire logic       phase_a_i,
  input  wire logic       phase_b_i,
  input  wire logic       enable_a_i,
  input  wire logic       enable_b_i,
  input  wire logic       mixed_decay_i,
  // Analog comparators
  input  wire logic       peak_a_i,
  input  wire logic       peak_b_i,
  input  wire logic       thermal_trip_i,
  input  wire logic       overcurrent_trip_i,
  // Gates and status
  output scp_pkg::scp_gates_t gates_a_o,
  output scp_pkg::scp_gates_t gates_b_o,
  output logic            chop_osc_clock_o,
  output logic            thermal_fault_o,
  output logic            overcurrent_fault_o
);
  import scp_pkg::*;

  // ****************************************************************
  // Chopper oscillator and period counter
  // ****************************************************************
  logic [4:0] div_q, div_d;
  logic       osc_q, osc_d;
  logic       tick_q, tick_d;
  logic [3:0] per_q, per_d;
  logic       start_q, start_d;
  logic       split_q, split_d;

  logic       stby_q;
  logic       tf_q, tf_d;
  logic       of_q, of_d;
  logic [2:0] oc_cnt_q, oc_cnt_d;
  logic       run_q, run_d;

  logic       stby_rise;
  assign stby_rise = standby_n_i && !stby_q;

  always_comb begin
    div_d   = div_q;
    osc_d   = osc_q;
    tick_d  = 1'b0;
    per_d   = per_q;
    start_d = 1'b0;
    split_d = 1'b0;
    if (!standby_n_i) begin
      div_d = 5'h0;
      osc_d = 1'b0;
      per_d = 4'h0;
    end else if (stby_rise) begin
      // Release opens a fresh period at once rather than waiting up to 16 ticks
      div_d   = 5'h0;
      per_d   = 4'h0;
      start_d = 1'b1;
    end else if (div_q == `SCP_OSC_DIV) begin
      div_d  = 5'h0;
      osc_d  = ~osc_q;
      tick_d = 1'b1;
      // Counter restarts when a period is complete
      if (per_q == `SCP_CHOP_TICKS) begin
        per_d   = 4'h0;
        start_d = 1'b1;
      end else begin
        per_d = per_q + 4'h1;
      end
      split_d = (per_q + 4'h1 == `SCP_SPLIT_TICKS);
    end else begin
      div_d = div_q + 5'h1;
    end
  end

  // ****************************************************************
  // Protection latches
  // ****************************************************************
  always_comb begin
    tf_d     = tf_q;
    of_d     = of_q;
    oc_cnt_d = oc_cnt_q;
    // A new thermal trip in the release cycle still wins
    if (stby_rise) begin
      tf_d = 1'b0;
      of_d = 1'b0;
    end
    if (thermal_trip_i) begin
      tf_d = 1'b1;
    end
    if (!overcurrent_trip_i || of_q) begin
      oc_cnt_d = 3'h0;
    end else if (tick_q) begin
      // Trip only after the level persists through the mask
      if (oc_cnt_q == `SCP_OC_MASK_TICKS - 3'h1) begin
        of_d = 1'b1;
      end else begin
        oc_cnt_d = oc_cnt_q + 3'h1;
      end
    end
    run_d = standby_n_i && !tf_d && !of_d;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q    <= 5'h0;
      osc_q    <= 1'b0;
      tick_q   <= 1'b0;
      per_q    <= 4'h0;
      start_q  <= 1'b0;
      split_q  <= 1'b0;
      stby_q   <= 1'b0;
      tf_q     <= 1'b0;
      of_q     <= 1'b0;
      oc_cnt_q <= 3'h0;
      run_q    <= 1'b0;
    end else if (ce_i) begin
      div_q    <= div_d;
      osc_q    <= osc_d;
      tick_q   <= tick_d;
      per_q    <= per_d;
      start_q  <= start_d;
      split_q  <= split_d;
      stby_q   <= standby_n_i;
      tf_q     <= tf_d;
      of_q     <= of_d;
      oc_cnt_q <= oc_cnt_d;
      run_q    <= run_d;
    end
  end

  // ****************************************************************
  // Bridges
  // ****************************************************************
  // A standby release starts a period, so chopping resumes two clocks later;
  // a bridge enabled mid-period waits for the next period start.
  scp_bridge u_bridge_a (
    .mclk_i         (mclk_i),
    .rstn_i         (rstn_i),
    .ce_i           (ce_i),
    .run_i          (run_q && enable_a_i),
    .period_start_i (start_q),
    .split_i        (split_q),
    .mixed_i        (mixed_decay_i),
    .dir_i          (phase_a_i),
    .peak_i         (peak_a_i),
    .gates_o        (gates_a_o)
  );

  scp_bridge u_bridge_b (
    .mclk_i         (mclk_i),
    .rstn_i         (rstn_i),
    .ce_i           (ce_i),
    .run_i          (run_q && enable_b_i),
    .period_start_i (start_q),
    .split_i        (split_q),
    .mixed_i        (mixed_decay_i),
    .dir_i          (phase_b_i),
    .peak_i         (peak_b_i),
    .gates_o        (gates_b_o)
  );

  assign chop_osc_clock_o    = osc_q;
  assign thermal_fault_o     = tf_q;
  assign overcurrent_fault_o = of_q;

endmodule

`default_nettype wire

// ===== testbench/scp_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host pins, relaunched on the clock so they only move at a sampling edge
module scp_host (
  input  wire logic       mclk_i,
  input  wire logic [3:0] req_i,
  output logic      [3:0] pins_o
);
  always_ff @(posedge mclk_i) pins_o <= req_i;
endmodule
`default_nettype wire

// ===== testbench/scp_core_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module scp_core_asserts
  import scp_pkg::*;
(
  // Watched ports
  input wire logic                mclk_i,
  input wire logic                rstn_i,
  input wire logic                standby_n_i,
  input wire logic                overcurrent_trip_i,
  input wire scp_pkg::scp_gates_t gates_a_o,
  input wire scp_pkg::scp_gates_t gates_b_o,
  input wire logic                chop_osc_clock_o,
  input wire logic                thermal_fault_o,
  input wire logic                overcurrent_fault_o,
  input wire logic                thermal_trip_i
);
  logic [8:0] run_q, run_d;
  logic       off;
  // Unbroken trip cycles; saturates so a stuck trip never wraps
  always_comb begin
    run_d = (overcurrent_trip_i && standby_n_i) ? run_q + {8'h0, run_q != 9'h1ff} : 9'h0;
    off   = gates_a_o == 4'h0 && gates_b_o == 4'h0;
  end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) run_q <= 9'h0;
    else run_q <= run_d;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence stby_hi; standby_n_i [*3]; endsequence
  sequence stby_lo; !standby_n_i [*5]; endsequence
  therm_set_a: assert property (thermal_trip_i |=> thermal_fault_o) else $error("thermal set");
  therm_hold_a: assert property (stby_hi ##0 thermal_fault_o |=> thermal_fault_o) else $error("thermal lost");
  oc_hold_a: assert property (stby_hi ##0 overcurrent_fault_o |=> overcurrent_fault_o) else $error("oc lost");
  oc_mask_a: assert property ($rose(overcurrent_fault_o) |-> run_q >= 9'd90) else $error("oc early");
  oc_late_a: assert property (run_q == 9'd250 |-> overcurrent_fault_o) else $error("oc late");
  fault_off_a: assert property (thermal_fault_o || overcurrent_fault_o |=> off) else $error("fault on");
  stby_off_a: assert property (stby_lo |-> off && $stable(chop_osc_clock_o)) else $error("standby on");
  sense_blank_a: assert property ($changed(gates_a_o) && $past(gates_a_o) inside {4'h0, 4'h3} && gates_a_o != 4'h0
    |=> ($stable(gates_a_o) || gates_a_o == 4'h0) [*8]) else $error("blank");
endmodule
`default_nettype wire
bind scp_core scp_core_asserts i_asserts (.mclk_i, .rstn_i, .standby_n_i, .overcurrent_trip_i, .gates_a_o,
  .gates_b_o, .chop_osc_clock_o, .thermal_fault_o, .overcurrent_fault_o, .thermal_trip_i);

// ===== testbench/tb_stepper_chopper_protection.sv
`timescale 1ns/10ps
`default_nettype none
module tb_stepper_chopper_protection;
  import scp_pkg::*;
  logic       mclk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       mixed = 1'b0;
  logic       pk = 1'b0;
  logic       tt = 1'b0;
  logic       oc = 1'b0;
  logic [3:0] req = 4'h0;
  logic [3:0] pins;
  logic       tf;
  logic       of;
  scp_gates_t ga;
  scp_gates_t gb;
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         cyc = 0;
  time        t0;
  // Host pins: {standby_n, enable, phase_b, phase_a}
  scp_host i_host (.mclk_i, .req_i(req), .pins_o(pins));
  scp_core i_dut (.mclk_i, .rstn_i, .ce_i(1'b1), .standby_n_i(pins[3]), .phase_a_i(pins[0]), .phase_b_i(pins[1]),
    .enable_a_i(pins[2]), .enable_b_i(pins[2]), .mixed_decay_i(mixed), .peak_a_i(pk), .peak_b_i(pk),
    .thermal_trip_i(tt), .overcurrent_trip_i(oc), .gates_a_o(ga), .gates_b_o(gb), .chop_osc_clock_o(),
    .thermal_fault_o(tf), .overcurrent_fault_o(of));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // Each level stands six clocks, well over the shortest phase pulse
  task automatic host(input logic [3:0] r);
    req = r;
    tick(6);
  endtask
  task automatic wt(input logic [3:0] e);
    for (int i = 0; i < 700 && ga !== e; i++) tick(1);
  endtask
  task automatic results;
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    tick(12);
    rstn_i = 1'b1;
    chk("rst", 4'h0, ga);
    mixed = 1'b1;
    req = 4'hf;
    wt(4'h9);
    t0 = $time;
    chk("chg_fwd", 4'h9, ga);
    tick(12);
    pk = 1'b1;
    tick(2);
    chk("fast_fwd", 4'h6, ga);
    wt(4'h3);
    chk("fast_len", 4'h1, 4'(($time - t0) / 20 inside {[184:188]}));
    pk = 1'b0;
    wt(4'h9);
    chk("period", 4'h1, 4'($time - t0 == 9920));
    tick(10);
    mixed = 1'b0;
    host(4'h4 | 4'h8);
    pk = 1'b1;
    wt(4'h3);
    pk = 1'b0;
    wt(4'h6);
    pk = 1'b1;
    tick(5);
    chk("blank", 4'h6, gb);
    tick(9);
    chk("slow_rev", 4'h3, ga);
    tt = 1'b1;
    tick(1);
    tt = 1'b0;
    tick(2);
    chk("therm", 4'h1, tf);
    chk("therm_off", 4'h0, ga);
    tick(50);
    chk("therm_hold", 4'h1, tf);
    host(4'h4);
    host(4'hc);
    chk("therm_clr", 4'h0, tf);
    oc = 1'b1;
    tick(90);
    oc = 1'b0;
    tick(3);
    chk("oc_mask", 4'h0, of);
    oc = 1'b1;
    tick(250);
    chk("oc_trip", 4'h1, of);
    chk("oc_off", 4'h0, ga);
    oc = 1'b0;
    tick(100);
    chk("oc_hold", 4'h1, of);
    host(4'h4);
    host(4'hc);
    chk("oc_clr", 4'h0, of);
    chk("resume", 4'h6, ga);
    results();
  end
endmodule
`default_nettype wire
